// [src/spx_top.sv]
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Emit backlash pulses at correction rate first
// RULE2 - Correct only when start reverses direction
// RULE3 - Backlash amount is twelve bits wide
// RULE4 - Enable bit gates backlash correction
// RULE5 - Per-counter enable for counting correction pulses
// RULE6 - After completion, one reverse then forward
// RULE7 - Suppression only when both delays nonzero
// RULE8 - Sixteen-bit delays, 1.6 us units
// RULE9 - Suppression forces completion at pulse width
// RULE10 - Polarity bit picks unipolar or bipolar
// RULE11 - Method bit picks four or eight steps
// RULE12 - Unipolar phase patterns per step
// RULE13 - Bipolar phase patterns per step
// RULE14 - Direction moves index; reverse bit swaps
// RULE15 - Pin select: status signals or phases
// RULE16 - Mask bit zero forces masked level
// RULE17 - Masked level LLLL or LLHH
// RULE18 - Odd step switching to 2-phase advances
// RULE19 - Status bits 24-27 show phase levels
// RULE20 - Correction pulses use new direction, step
// RULE21 - Reset: step zero, direction history matches
module spx_top #(
  parameter int UNIT_CYC = spx_pkg::VIB_UNIT_CYC
) (
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic        clk_en_in,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Pulse generator side
  input  wire logic        start_req_in,
  input  wire logic        start_dir_in,
  input  wire logic        correction_speed_in,
  input  wire logic        cmd_pulse_in,
  input  wire logic        cmd_last_in,
  input  wire logic        op_done_in,
  input  wire logic        motion_busy_in,
  input  wire logic        accelerating_in,
  input  wire logic        decelerating_in,
  input  wire logic        constant_speed_in,
  // Outputs
  output logic             start_grant_out,
  output logic             pulse_out,
  output logic             dir_out,
  output logic [2:0]       count_en_out,
  output logic             op_complete_out,
  output logic [3:0]       shared_pins_out
);
  import spx_pkg::*;

  // Elaboration check
  generate
    if (UNIT_CYC < 1) begin : g_bad_unit
      $error("UNIT_CYC must be at least one");
    end
  endgenerate

  // Register bus state
  logic [31:0] counter_environment_r;
  logic [31:0] backlash_config_r;
  logic [31:0] vibration_delay_r;
  logic [31:0] operation_mode_r;
  logic [31:0] environment_one_r;
  logic        aw_have_r;
  logic        w_have_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_fire;
  logic [31:0] ext_status;

  // Control fields
  logic [2:0]             counter_count_during_backlash;
  logic [BL_AMOUNT_W-1:0] backlash_amount;
  logic                   backlash_enable;
  logic [DELAY_W-1:0]     reverse_delay;
  logic [DELAY_W-1:0]     forward_delay;
  logic                   vib_active;
  logic                   completion_timing_select;
  logic                   excitation_method_select;
  logic                   rotation_reverse;

  // Sequencing state
  spx_state_type          state_r;
  logic                   last_dir_r;
  logic                   history_r;
  logic                   move_dir_r;
  logic [BL_AMOUNT_W-1:0] bl_left_r;
  logic [DELAY_W-1:0]     dly_r;
  logic [31:0]            pre_r;
  logic                   done_sent_r;
  logic                   unit_tick;
  logic                   emit;
  logic                   emit_dir;
  logic                   emit_bl;
  logic                   reversal;
  logic [3:0]             phase_live;

  spx_step_if step_bus ();

  // Address to register slot; 7 means unmapped
  function automatic logic [2:0] reg_slot(input logic [7:0] a);
    logic [2:0] s;
    s = 3'd7;
    unique case (a)
      OFS_COUNTER_ENV:  s = 3'd0;
      OFS_BACKLASH_CFG: s = 3'd1;
      OFS_VIB_DELAY:    s = 3'd2;
      OFS_OPER_MODE:    s = 3'd3;
      OFS_ENV_ONE:      s = 3'd4;
      OFS_EXT_STATUS:   s = 3'd5;
      default:          s = 3'd7;
    endcase
    return s;
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) m[8*b +: 8] = nw[8*b +: 8];
    end
    return m;
  endfunction

  // Field extraction
  assign counter_count_during_backlash =
    counter_environment_r[CNT_EN_LSB +: 3];
  assign backlash_amount =
    backlash_config_r[BL_AMOUNT_LSB +: BL_AMOUNT_W]; // RULE3
  assign backlash_enable = backlash_config_r[BL_ENABLE_BIT];
  assign reverse_delay   = vibration_delay_r[REV_DELAY_LSB +: DELAY_W];
  assign forward_delay   = vibration_delay_r[FWD_DELAY_LSB +: DELAY_W];
  assign vib_active = (reverse_delay != '0) && (forward_delay != '0); // RULE7
  assign completion_timing_select = operation_mode_r[DONE_TIMING_BIT];
  assign excitation_method_select = operation_mode_r[EXC_METHOD_BIT];
  assign rotation_reverse         = environment_one_r[ROT_REVERSE_BIT];

  // Write and read channel handshakes
  assign s_axi_awready_out = !aw_have_r && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_have_r && !s_axi_bvalid_out;
  assign wr_fire           = aw_have_r && w_have_r && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;

  // Write address and data capture, either order
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else if (clk_en_in) begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_in;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // Register storage and write response
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      counter_environment_r <= RST_COUNTER_ENV;
      backlash_config_r     <= RST_BACKLASH_CFG;
      vibration_delay_r     <= RST_VIB_DELAY;
      operation_mode_r      <= RST_OPER_MODE;
      environment_one_r     <= RST_ENV_ONE;
      s_axi_bvalid_out      <= 1'b0;
      s_axi_bresp_out       <= RESP_OKAY;
    end else if (clk_en_in) begin
      if (wr_fire) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= RESP_OKAY;
        unique case (reg_slot(aw_addr_r))
          3'd0: counter_environment_r <=
                  merge(counter_environment_r, w_data_r, w_strb_r); // RULE5
          3'd1: backlash_config_r <=
                  merge(backlash_config_r, w_data_r, w_strb_r); // RULE4
          3'd2: vibration_delay_r <=
                  merge(vibration_delay_r, w_data_r, w_strb_r); // RULE8
          3'd3: operation_mode_r <=
                  merge(operation_mode_r, w_data_r, w_strb_r);
          3'd4: environment_one_r <=
                  merge(environment_one_r, w_data_r, w_strb_r);
          3'd5: s_axi_bresp_out <= RESP_OKAY; // Status ignores writes
          default: s_axi_bresp_out <= RESP_SLVERR;
        endcase
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Status word: phase levels, step index, busy
  always_comb begin
    ext_status = 32'h0000_0000;
    ext_status[PHASE_STAT_LSB +: 4] = {phase_live[0], phase_live[1],
                                       phase_live[2], phase_live[3]}; // RULE19
    ext_status[STEP_STAT_LSB +: 3] = step_bus.index;
    ext_status[0] = (state_r != SPX_IDLE);
  end

  // Read channel; write-only registers read as zero
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= RESP_OKAY;
    end else if (clk_en_in) begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out  <= 32'h0000_0000;
        s_axi_rresp_out  <= RESP_OKAY;
        unique case (reg_slot(s_axi_araddr_in))
          3'd5: s_axi_rdata_out <= ext_status; // RULE19
          3'd7: s_axi_rresp_out <= RESP_SLVERR;
          default: s_axi_rdata_out <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // Reversal test; no history after reset counts as matching
  assign reversal = history_r && (start_dir_in != last_dir_r); // RULE2 RULE21

  // Delay unit prescaler, runs only while waiting
  assign unit_tick = (pre_r == 32'(UNIT_CYC - 1));
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_r <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if ((state_r == SPX_REV_WAIT || state_r == SPX_FWD_WAIT)
          && !unit_tick) begin
        pre_r <= pre_r + 32'h0000_0001; // RULE8
      end else begin
        pre_r <= 32'h0000_0000;
      end
    end
  end

  // Pulse source selection for this cycle
  always_comb begin
    emit     = 1'b0;
    emit_dir = move_dir_r;
    emit_bl  = 1'b0;
    unique case (state_r)
      SPX_BACKLASH: begin
        emit    = correction_speed_in; // RULE1
        emit_bl = 1'b1;
      end
      SPX_MOVE: begin
        emit = cmd_pulse_in;
      end
      SPX_REV_WAIT: begin
        emit     = unit_tick && (dly_r == 16'h0001); // RULE6
        emit_dir = !move_dir_r;
      end
      SPX_FWD_WAIT: begin
        emit = unit_tick && (dly_r == 16'h0001); // RULE6
      end
      SPX_IDLE: begin
        emit = 1'b0;
      end
    endcase
  end

  // Move sequencer
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r     <= SPX_IDLE;
      last_dir_r  <= 1'b0;
      history_r   <= 1'b0; // RULE21
      move_dir_r  <= 1'b0;
      bl_left_r   <= '0;
      dly_r       <= '0;
      done_sent_r <= 1'b0;
    end else if (clk_en_in) begin
      unique case (state_r)
        SPX_IDLE: begin
          if (start_req_in) begin
            move_dir_r  <= start_dir_in;
            last_dir_r  <= start_dir_in;
            history_r   <= 1'b1;
            done_sent_r <= 1'b0;
            bl_left_r   <= backlash_amount;
            if (backlash_enable && reversal
                && backlash_amount != '0) begin // RULE2 RULE4
              state_r <= SPX_BACKLASH;
            end else begin
              state_r <= SPX_MOVE;
            end
          end
        end
        SPX_BACKLASH: begin
          if (correction_speed_in) begin
            bl_left_r <= bl_left_r - 1'b1; // RULE1
            if (bl_left_r == 12'h001) begin
              state_r <= SPX_MOVE;
            end
          end
        end
        SPX_MOVE: begin
          if (cmd_pulse_in && cmd_last_in) begin
            done_sent_r <= completion_timing_select && !vib_active;
          end
          if (op_done_in) begin
            if (vib_active) begin // RULE7
              dly_r   <= reverse_delay; // RULE8
              state_r <= SPX_REV_WAIT;
            end else begin
              state_r <= SPX_IDLE;
            end
          end
        end
        SPX_REV_WAIT: begin
          if (unit_tick) begin
            dly_r <= dly_r - 1'b1;
            if (dly_r == 16'h0001) begin
              dly_r   <= forward_delay; // RULE8
              state_r <= SPX_FWD_WAIT;
            end
          end
        end
        SPX_FWD_WAIT: begin
          if (unit_tick) begin
            dly_r <= dly_r - 1'b1;
            if (dly_r == 16'h0001) begin
              state_r <= SPX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Grant pulse: move may begin once correction is over
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_grant_out <= 1'b0;
    end else if (clk_en_in) begin
      start_grant_out <=
        (state_r == SPX_IDLE && start_req_in
         && !(backlash_enable && reversal && backlash_amount != '0))
        || (state_r == SPX_BACKLASH && correction_speed_in
            && bl_left_r == 12'h001); // RULE1
    end
  end

  // Output pulse, direction and counter enables
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pulse_out    <= 1'b0;
      dir_out      <= 1'b0;
      count_en_out <= 3'b000;
    end else if (clk_en_in) begin
      pulse_out <= emit;
      if (emit) begin
        dir_out <= emit_dir; // RULE20
      end
      count_en_out <= emit_bl ? {3{emit}} & counter_count_during_backlash
                              : {3{emit}}; // RULE5
    end
  end

  // Completion: end of pulse width, or cycle end from the generator
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      op_complete_out <= 1'b0;
    end else if (clk_en_in) begin
      op_complete_out <=
        (state_r == SPX_FWD_WAIT && emit) // RULE9
        || (state_r == SPX_MOVE && !vib_active && cmd_pulse_in
            && cmd_last_in && completion_timing_select)
        || (state_r == SPX_MOVE && !vib_active && op_done_in
            && !completion_timing_select && !done_sent_r);
    end
  end

  // Excitation sequencer, stepped by every output pulse
  assign step_bus.step      = emit; // RULE20
  assign step_bus.dir       = emit_dir;
  assign step_bus.bipolar   = operation_mode_r[DRIVE_POL_BIT]; // RULE10
  assign step_bus.half_step = excitation_method_select; // RULE11
  assign step_bus.reverse   = rotation_reverse; // RULE14

  spx_excite u_excite (
    .clock_in  (clock_in),
    .nrst_in   (nrst_in),
    .clk_en_in (clk_en_in),
    .st        (step_bus)
  );

  // Phase masking to the selected level
  assign phase_live = operation_mode_r[MASK_CTL_BIT] ? step_bus.phase
                    : (operation_mode_r[MASK_LEVEL_BIT] ? MASK_LLHH
                                                        : MASK_LLLL);
                    // RULE16 RULE17

  // Shared pins: status group or phases, bit 0 = first pin
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shared_pins_out <= 4'h0;
    end else if (clk_en_in) begin
      if (operation_mode_r[PIN_SELECT_BIT]) begin
        shared_pins_out <= {phase_live[0], phase_live[1],
                            phase_live[2], phase_live[3]}; // RULE15
      end else begin
        shared_pins_out <= {constant_speed_in, decelerating_in,
                            accelerating_in, motion_busy_in}; // RULE15
      end
    end
  end
endmodule

// [src/spx_pkg.sv]
package spx_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_COUNTER_ENV  = 8'h00;
  localparam logic [7:0] OFS_BACKLASH_CFG = 8'h04;
  localparam logic [7:0] OFS_VIB_DELAY    = 8'h08;
  localparam logic [7:0] OFS_OPER_MODE    = 8'h0C;
  localparam logic [7:0] OFS_ENV_ONE      = 8'h10;
  localparam logic [7:0] OFS_EXT_STATUS   = 8'h14;

  // Field positions
  localparam int CNT_EN_LSB      = 24; // Three counter enables, 26:24
  localparam int BL_AMOUNT_LSB   = 0;  // Backlash amount, 11:0
  localparam int BL_AMOUNT_W     = 12;
  localparam int BL_ENABLE_BIT   = 15;
  localparam int REV_DELAY_LSB   = 0;  // Reverse delay, 15:0
  localparam int FWD_DELAY_LSB   = 16; // Forward delay, 31:16
  localparam int DELAY_W         = 16;
  localparam int DONE_TIMING_BIT = 12;
  localparam int PIN_SELECT_BIT  = 16;
  localparam int MASK_CTL_BIT    = 17;
  localparam int DRIVE_POL_BIT   = 18;
  localparam int EXC_METHOD_BIT  = 19;
  localparam int MASK_LEVEL_BIT  = 25;
  localparam int ROT_REVERSE_BIT = 0;
  localparam int PHASE_STAT_LSB  = 24;
  localparam int STEP_STAT_LSB   = 1;

  // Reset values
  localparam logic [31:0] RST_COUNTER_ENV  = 32'h0000_0000;
  localparam logic [31:0] RST_BACKLASH_CFG = 32'h0000_0000;
  localparam logic [31:0] RST_VIB_DELAY    = 32'h0000_0000;
  localparam logic [31:0] RST_OPER_MODE    = 32'h0000_0000;
  localparam logic [31:0] RST_ENV_ONE      = 32'h0000_0000;

  // Masked phase levels, phase 1 in bit 3
  localparam logic [3:0] MASK_LLLL = 4'h0;
  localparam logic [3:0] MASK_LLHH = 4'h3;

  // Timing
  localparam int CLK_MHZ       = 50;
  localparam int VIB_UNIT_NS   = 1600;
  localparam int VIB_UNIT_CYC  = (VIB_UNIT_NS * CLK_MHZ) / 1000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SPX_IDLE,
    SPX_BACKLASH,
    SPX_MOVE,
    SPX_REV_WAIT,
    SPX_FWD_WAIT
  } spx_state_type;

endpackage

// [src/spx_step_if.sv]
`timescale 1ns/1ps
interface spx_step_if;
  logic       step;
  logic       dir;
  logic       bipolar;
  logic       half_step;
  logic       reverse;
  logic [3:0] phase;
  logic [2:0] index;

  modport seq (input step, dir, bipolar, half_step, reverse,
               output phase, index);
  modport ctl (output step, dir, bipolar, half_step, reverse,
               input phase, index);
endinterface

// [src/spx_excite.sv]
`timescale 1ns/1ps
module spx_excite (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  spx_step_if.seq  st
);
  import spx_pkg::*;

  logic [2:0] idx_r;
  logic [2:0] idx_nxt;
  logic [2:0] stride;
  logic       fwd;

  // Eight-entry pattern, phase 1 in bit 3; 2-phase uses even entries
  function automatic logic [3:0] phase_of(input logic bip,
                                          input logic [2:0] i);
    logic [3:0] p;
    p = 4'h0;
    if (bip) begin
      unique case (i) // RULE13
        3'd0: p = 4'h8;
        3'd1: p = 4'h9;
        3'd2: p = 4'hC;
        3'd3: p = 4'hE;
        3'd4: p = 4'h4;
        3'd5: p = 4'h5;
        3'd6: p = 4'h0;
        3'd7: p = 4'h2;
      endcase
    end else begin
      unique case (i) // RULE12
        3'd0: p = 4'h9;
        3'd1: p = 4'h8;
        3'd2: p = 4'hC;
        3'd3: p = 4'h4;
        3'd4: p = 4'h6;
        3'd5: p = 4'h2;
        3'd6: p = 4'h3;
        3'd7: p = 4'h1;
      endcase
    end
    return p;
  endfunction

  // Step direction and stride; odd index in 2-phase lands on even
  always_comb begin
    fwd    = st.dir ^ st.reverse; // RULE14
    stride = (!st.half_step && !idx_r[0]) ? 3'd2 : 3'd1; // RULE11 RULE18
    idx_nxt = fwd ? idx_r + stride : idx_r - stride; // RULE14
  end

  // Step index, starts at step 0
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idx_r <= 3'd0; // RULE21
    end else if (clk_en_in && st.step) begin
      idx_r <= idx_nxt; // RULE12
    end
  end

  assign st.phase = phase_of(st.bipolar, idx_r); // RULE10
  assign st.index = idx_r;
endmodule

// [dv/spx_properties.sv]
`timescale 1ns/1ps
module spx_properties (
  input wire logic       clock_in,
  input wire logic       nrst_in,
  input wire logic       s_axi_awready_out,
  input wire logic       s_axi_bvalid_out,
  input wire logic       s_axi_bready_in,
  input wire logic       s_axi_arvalid_in,
  input wire logic       s_axi_arready_out,
  input wire logic       s_axi_rvalid_out,
  input wire logic       s_axi_rready_in,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic       pulse_out,
  input wire logic       dir_out,
  input wire logic [2:0] count_en_out,
  input wire logic       op_complete_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out) else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out) else $error("read data dropped");
  AST_R_STABLE: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> $stable(s_axi_rresp_out)) else $error("read response changed");
  AST_AW_REFUSE: assert property (s_axi_bvalid_out |-> !s_axi_awready_out)
    else $error("write address taken during response");
  AST_R_CAUSE: assert property ($rose(s_axi_rvalid_out)
    |-> $past(s_axi_arvalid_in && s_axi_arready_out))
    else $error("read data without request");
  AST_COUNT_PULSE: assert property (|count_en_out |-> pulse_out)
    else $error("count enable without pulse");
  AST_DIR_PULSE: assert property ($changed(dir_out) |-> pulse_out)
    else $error("direction changed without pulse");
  AST_DONE_ONE: assert property (op_complete_out |=> !op_complete_out)
    else $error("completion longer than one cycle");
endmodule

bind spx_top spx_properties u_spx_properties (.*);

// [dv/spx_drv_model.sv]
`timescale 1ns/1ps
// Driver stage: latches the coil pattern and counts step pulses
module spx_drv_model (
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic        pulse_in,
  input  wire logic [3:0]  coil_in,
  output logic      [15:0] steps_out,
  output logic      [3:0]  coil_out
);
  // Coil latch and step counter
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      steps_out <= 16'h0000;
      coil_out  <= 4'h0;
    end else begin
      coil_out <= coil_in;
      if (pulse_in) steps_out <= steps_out + 16'h0001;
    end
  end
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import spx_pkg::*;
  localparam int UC = 2;
  logic        clock_in = 1'b0, nrst_in = 1'b0, clk_en_in = 1'b1;
  logic [7:0]  s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0000_0000, s_axi_rdata_out, q;
  logic [3:0]  s_axi_wstrb_in = 4'hF, st_vec = 4'h0, shared_pins_out, coil;
  logic        s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
  logic        s_axi_arvalid_in = 0, s_axi_rready_in = 0, bip = 0, half = 0;
  logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic        s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rsp;
  logic        start_req_in = 0, start_dir_in = 0, correction_speed_in = 0;
  logic        cmd_pulse_in = 0, cmd_last_in = 0, op_done_in = 0;
  logic        start_grant_out, pulse_out, dir_out, op_complete_out;
  logic [2:0]  count_en_out;
  logic [15:0] steps;
  int          fails = 0, tests_run = 0, idx = 0, rev = 0, last = -1, bl = 0;

  spx_top #(.UNIT_CYC(UC)) u_spx_top (.clock_in, .nrst_in, .clk_en_in,
    .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
    .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
    .start_req_in, .start_dir_in, .correction_speed_in, .cmd_pulse_in,
    .cmd_last_in, .op_done_in, .motion_busy_in(st_vec[0]),
    .accelerating_in(st_vec[1]), .decelerating_in(st_vec[2]),
    .constant_speed_in(st_vec[3]), .start_grant_out, .pulse_out, .dir_out,
    .count_en_out, .op_complete_out, .shared_pins_out);
  spx_drv_model u_spx_drv_model (.clock_in, .nrst_in, .pulse_in(pulse_out),
    .coil_in(shared_pins_out), .steps_out(steps), .coil_out(coil));

  // Free-running clock
  always #10 clock_in = ~clock_in;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bus access; ready comes a cycle late, stalling read data; the write response is taken in its first cycle
  task automatic axi(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    logic aw, w, ar, done;
    @(posedge clock_in);
    s_axi_awaddr_in  <= a;
    s_axi_araddr_in  <= a;
    s_axi_wdata_in   <= d;
    s_axi_awvalid_in <= we;
    s_axi_wvalid_in  <= we;
    s_axi_arvalid_in <= !we;
    done = 1'b0;
    for (int n = 0; n < 64 && !done; n++) begin
      @(negedge clock_in);
      aw = s_axi_awvalid_in && s_axi_awready_out;
      w = s_axi_wvalid_in && s_axi_wready_out;
      ar = s_axi_arvalid_in && s_axi_arready_out;
      done = we ? s_axi_bvalid_out && s_axi_bready_in
                : s_axi_rvalid_out && s_axi_rready_in;
      r = s_axi_rdata_out;
      rsp = we ? s_axi_bresp_out : s_axi_rresp_out;
      @(posedge clock_in);
      if (aw) s_axi_awvalid_in <= 1'b0;
      if (w) s_axi_wvalid_in <= 1'b0;
      if (ar) s_axi_arvalid_in <= 1'b0;
      s_axi_bready_in <= we && !done && n > 0;
      s_axi_rready_in <= !we && !done && n > 0;
    end
    if (!done) fails++;
  endtask

  function automatic int nx(input int i, input logic up);
    int s;
    s = (half || i[0]) ? 1 : 2;
    return up ? (i + s) % 8 : (i + 8 - s) % 8;
  endfunction

  // Phase pattern per step index, phase 1 in bit 0
  task automatic ph_chk;
    logic [3:0] e;
    e = 4'((bip ? 32'h40A2_7391 : 32'h8C46_2319) >> (4 * idx));
    axi(1'b0, OFS_EXT_STATUS, 32'h0000_0000, q);
    chk(q[27:24], e);
    chk(q[3:1], idx[2:0]);
    chk(coil, e);
  endtask

  // Start, correction ticks, one command pulse, done, then suppression
  task automatic move(input logic d, input int nv);
    int c0, t1, t2, n, nb;
    logic up, dr;
    up = d ^ rev[0];
    nb = (last >= 0 && d != last) ? bl : 0;
    last = d;
    c0 = steps;
    @(posedge clock_in);
    start_req_in <= 1'b1;
    start_dir_in <= d;
    @(posedge clock_in);
    start_req_in <= 1'b0;
    @(negedge clock_in);
    for (n = 0; n < 40 && start_grant_out !== 1'b1; n++) begin
      @(posedge clock_in);
      correction_speed_in <= n[0];
      @(negedge clock_in);
      if (pulse_out === 1'b1) chk(count_en_out, 3'b101);
    end
    @(negedge clock_in);
    chk(steps - c0, nb);
    for (n = 0; n < nb; n++) idx = nx(idx, up);
    @(posedge clock_in);
    cmd_pulse_in <= 1'b1;
    cmd_last_in  <= 1'b1;
    @(posedge clock_in);
    cmd_pulse_in <= 1'b0;
    cmd_last_in  <= 1'b0;
    idx = nx(idx, up);
    @(posedge clock_in);
    op_done_in <= 1'b1;
    @(posedge clock_in);
    op_done_in <= 1'b0;
    c0 = steps;
    for (n = 1; n < 400; n++) begin
      @(negedge clock_in);
      if (pulse_out === 1'b1 && t1 == 0) begin
        t1 = n;
        dr = dir_out;
      end else if (pulse_out === 1'b1) t2 = n;
      if (op_complete_out === 1'b1) break;
    end
    if (n == 400) fails++;
    @(negedge clock_in); // Let the model count the last pulse
    chk(steps - c0, nv);
    if (nv == 2) begin
      chk(dr, !d);
      chk(t1, 3 * UC + 1);
      chk(t2 - t1, 2 * UC);
      chk(n - t2, 0);
    end
    ph_chk;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clock_in);
    nrst_in <= 1'b1;
    axi(1'b0, OFS_EXT_STATUS, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    axi(1'b0, 8'h40, 32'h0000_0000, q);
    chk(rsp, RESP_SLVERR);
    axi(1'b1, OFS_OPER_MODE, 32'h0201_0000, q);
    repeat (2) @(negedge clock_in);
    chk(shared_pins_out, 4'hC);
    axi(1'b1, OFS_OPER_MODE, 32'h0000_0000, q);
    st_vec <= 4'hA;
    repeat (3) @(negedge clock_in);
    chk(shared_pins_out, 4'hA);
    $display("test pins done at %0t", $time);
    for (int m = 0; m < 4; m++) begin
      bip = m[1];
      half = !m[0];
      axi(1'b1, OFS_OPER_MODE, {12'h000, half, bip, 2'b11, 16'h0000}, q);
      for (int k = 0; k < 11; k++) move(k < 7, 0);
      $display("test mode %0d done at %0t", m, $time);
    end
    axi(1'b1, OFS_ENV_ONE, 32'h0000_0001, q);
    rev = 1;
    move(1'b1, 0);
    axi(1'b1, OFS_COUNTER_ENV, 32'h0500_0000, q);
    axi(1'b1, OFS_BACKLASH_CFG, 32'h0000_F003, q);
    bl = 3;
    move(1'b0, 0);
    move(1'b0, 0);
    $display("test backlash done at %0t", $time);
    axi(1'b1, OFS_VIB_DELAY, 32'h0000_0003, q);
    move(1'b0, 0);
    axi(1'b1, OFS_VIB_DELAY, 32'h0002_0003, q);
    move(1'b0, 2);
    $display("test vibration done at %0t", $time);
    stop_test;
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge clock_in);
    fails++;
    stop_test;
  end
endmodule
